// ==== dv/lvq_core_asserts.sv ====
// Port checker for the quantizer core.
// Assumes it is bound to lvq_core from the bench top file.
`timescale 1ns/1ps
module lvq_core_asserts import lvq_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [BITS_W-1:0] available_bit_count,
  input wire lvq_coef_vec_t coef_in,
  input wire logic busy,
  input wire logic done,
  input wire logic [GAIN_W-1:0] gain,
  input wire lvq_point_vec_t quant_point,
  input wire lvq_coef_vec_t quant_spectrum,
  input wire lvq_band_vec_t band_index
);
  // Unity gain in the 16 fraction bit format
  localparam logic [GAIN_W-1:0] GAIN_ONE = 44'h00000010000;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // ------
  // Job sequencing
  // ------
  sequence take_s;
    start && !busy;
  endsequence
  sequence quiet_s;
    (busy && !done) [*8];
  endsequence

  start_take_a: assert property (take_s |=> quiet_s)
    else $error("core not busy after accepted start");
  // Done is set by the code step and first seen high one edge later, hence 94 to 133
  done_time_a: assert property (take_s |-> ##[94:133] $rose(done))
    else $error("done outside expected latency");
  done_idle_a: assert property (done |-> !busy)
    else $error("done while busy");
  busy_end_a: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  result_hold_a: assert property (done && !start |=> done && $stable(gain) && $stable(band_index))
    else $error("results moved while idle");

  // ------
  // Result fields
  // ------
  // Offset never goes negative, so gain is at least one
  gain_floor_a: assert property (done |-> gain >= GAIN_ONE)
    else $error("gain below one");
  cb_legal_a: assert property (done |-> band_index[0].cb_num != 4'h1 && band_index[0].cb_num <= 4'h8)
    else $error("illegal codebook number");
  ext_pair_a: assert property (done |-> (band_index[0].ext_order != 2'h0) == (band_index[0].cb_num > 4'h4))
    else $error("extension order disagrees with codebook");
endmodule : lvq_core_asserts

// ==== dv/lvq_enc_model.sv ====
// Encoder core stand-in: offers one job at a time to the quantizer.
// Assumes the bench pulses go for one cycle with the job settings.
`timescale 1ns/1ps
module lvq_enc_model import lvq_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic nag,
  input wire logic [BITS_W-1:0] bits_cfg,
  input wire lvq_coef_vec_t coef_cfg,
  input wire logic busy,
  input wire logic done,
  output logic start,
  output logic [BITS_W-1:0] available_bit_count,
  output lvq_coef_vec_t coef_in
);
  logic active;
  logic [3:0] age;

  // Start pulse, hold until done, then flip data so stale values never match
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      start <= 1'b0;
      active <= 1'b0;
      age <= 4'h0;
      available_bit_count <= '0;
      coef_in <= '0;
    end else if (go) begin
      start <= 1'b1;
      active <= 1'b1;
      age <= 4'h0;
      available_bit_count <= bits_cfg;
      coef_in <= coef_cfg;
    end else if (active) begin
      if (age != 4'hF) begin
        age <= age + 4'h1;
      end
      // Extra start only in mid-job, where the core must ignore it
      start <= nag && (age inside {[4'h2:4'h5]});
      if (done && !start) begin
        active <= 1'b0;
        available_bit_count <= ~available_bit_count;
        coef_in <= ~coef_in;
      end
    end
  end
endmodule : lvq_enc_model

// ==== dv/tb_lvq_core.sv ====
// Self-checking bench for the lattice vector quantizer core.
// Assumes the encoder stand-in model and the bound port checker.
`timescale 1ns/1ps
module tb_lvq_core import lvq_pkg::*; ;
  logic core_clk = 1'b0;
  logic reset_n = 1'b1;
  logic go = 1'b0;
  logic nag = 1'b0;
  logic [BITS_W-1:0] bits_cfg = '0;
  lvq_coef_vec_t coef_cfg = '0;
  logic start;
  logic [BITS_W-1:0] available_bit_count;
  lvq_coef_vec_t coef_in;
  logic busy;
  logic done;
  logic [GAIN_W-1:0] gain;
  lvq_point_vec_t quant_point;
  lvq_coef_vec_t quant_spectrum;
  lvq_band_vec_t band_index;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  lvq_core u_lvq_core (.core_clk(core_clk), .reset_n(reset_n), .start(start),
    .available_bit_count(available_bit_count), .coef_in(coef_in), .busy(busy), .done(done),
    .gain(gain), .quant_point(quant_point), .quant_spectrum(quant_spectrum), .band_index(band_index));

  lvq_enc_model u_lvq_enc_model (.core_clk(core_clk), .reset_n(reset_n), .go(go), .nag(nag),
    .bits_cfg(bits_cfg), .coef_cfg(coef_cfg), .busy(busy), .done(done), .start(start),
    .available_bit_count(available_bit_count), .coef_in(coef_in));

  // ------
  // Compare and job tasks
  // ------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Range compare where fixed-point rounding is the designer's own
  task automatic chk_in(input string what, input logic [63:0] lo, input logic [63:0] hi, input logic [63:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("[ERR] %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_in

  task automatic chk_band(input int j, input logic [3:0] cb, input logic [7:0] code, input logic [3:0] len);
    chk("cb_num", cb, band_index[j].cb_num);
    chk("unary_code", code, band_index[j].unary_code);
    chk("unary_len", len, band_index[j].unary_len);
  endtask : chk_band

  // Hand a job to the model and wait for done, bounded
  task automatic job(input logic [BITS_W-1:0] bits, input lvq_coef_vec_t cv, input logic pester);
    int n;
    n = 0;
    @(posedge core_clk);
    go <= 1'b1;
    bits_cfg <= bits;
    coef_cfg <= cv;
    nag <= pester;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("busy", 64'h1, busy);
    while (done !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("done", 64'h1, done);
    chk("busy", 64'h0, busy);
  endtask : job

  // ------
  // Scenarios
  // ------
  // Silent input: floor keeps estimates at zero, odd coset wins the tie-free pick
  task automatic t_zero();
    job(16'h0064, '0, 1'b0);
    chk("gain", 64'h10000, gain);
    for (int k = 0; k < N_COEF; k++) begin
      chk("point", 64'h1, quant_point[k]);
      chk("spectrum", 64'h10, quant_spectrum[k]);
    end
    for (int j = 0; j < SUBBAND_COUNT; j++) begin
      chk_band(j, 4'h2, 8'h02, 4'h2);
    end
  endtask : t_zero

  // Budget leaves 5n-1 bits for the last band, so its ending zero goes
  task automatic t_short();
    job(16'h004F, '0, 1'b0);
    for (int j = 0; j < SUBBAND_COUNT - 1; j++) begin
      chk_band(j, 4'h2, 8'h02, 4'h2);
    end
    chk_band(7, 4'h2, 8'h01, 4'h1);
  endtask : t_short

  // One loud band, zero ceiling: offset settles at 34.75
  task automatic t_search();
    lvq_coef_vec_t cv;
    cv = '0;
    cv[0] = 16'h0100;
    job(16'h0008, cv, 1'b0);
    chk_in("gain", 64'hB0000, 64'hB4000, gain);
    chk("point", 64'h1, quant_point[0]);
    chk_in("spectrum", 64'hB0, 64'hB4, quant_spectrum[1]);
  endtask : t_search

  // Extension, even pick and parity fix, with stray starts while busy
  task automatic t_mixed();
    lvq_coef_vec_t cv;
    cv = '0;
    for (int k = 0; k < 8; k++) begin
      cv[k] = 16'h0040;
      cv[k + 8] = 16'h0010;
      cv[k + 24] = 16'h000E;
    end
    cv[16] = 16'h0030;
    job(16'h03E8, cv, 1'b1);
    chk("gain", 64'h10000, gain);
    chk("point", 64'h5, quant_point[0]);
    chk("spectrum", 64'h50, quant_spectrum[0]);
    chk_band(0, 4'h5, 8'h1E, 4'h5);
    chk("ext_order", 64'h1, band_index[0].ext_order);
    chk("base_point", 64'h2, band_index[0].base_point[0]);
    chk("ext_point", 64'h1, band_index[0].ext_point[0]);
    chk("no_fit", 64'h0, band_index[0].no_fit);
    chk("point", 64'h2, quant_point[8]);
    chk_band(1, 4'h3, 8'h06, 4'h3);
    chk("ext_order", 64'h0, band_index[1].ext_order);
    chk("point", 64'h3, quant_point[16]);
    chk("point", 64'h3FFF, quant_point[17]);
    chk("point", 64'h1, quant_point[18]);
    chk_band(2, 4'h2, 8'h02, 4'h2);
    // Band of 0.875s: the even origin is farther, so it is the one taken
    chk("point", 64'h0, quant_point[24]);
    chk("spectrum", 64'h0, quant_spectrum[24]);
    chk_band(3, 4'h0, 8'h00, 4'h1);
  endtask : t_mixed

  task automatic results();
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Hang guard, far above four jobs of at most 140 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end

  // Main sequence; jobs run back to back while done stands
  initial begin
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_zero();
    t_short();
    t_search();
    t_mixed();
    results();
  end
endmodule : tb_lvq_core

bind lvq_core lvq_core_asserts u_lvq_core_asserts (.core_clk(core_clk), .reset_n(reset_n), .start(start),
  .available_bit_count(available_bit_count), .coef_in(coef_in), .busy(busy), .done(done), .gain(gain),
  .quant_point(quant_point), .quant_spectrum(quant_spectrum), .band_index(band_index));

// ==== rtl/lvq_core.sv ====
// Lattice vector quantizer core: gain search, nearest point search, codebook numbers.
// Assumes the encoder core holds coefficients and bit budget stable from start until done.
`timescale 1ns/1ps
module lvq_core import lvq_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [BITS_W-1:0] available_bit_count,
  input wire lvq_coef_vec_t coef_in,
  output logic busy,
  output logic done,
  output logic [GAIN_W-1:0] gain,
  output lvq_point_vec_t quant_point,
  output lvq_coef_vec_t quant_spectrum,
  output lvq_band_vec_t band_index
);

  typedef struct packed {
    lvq_phase_t phase;
    logic [2:0] band;
    logic [3:0] cnt;
    logic signed [R_W-1:0] fac;
    logic signed [R_W-1:0] offset;
    logic [SUBBAND_COUNT-1:0][R_W-1:0] rate;
    logic [LMANT_W-1:0] lmant;
    logic signed [7:0] lint;
    logic [LOG_FRAC-1:0] lfrac;
    logic [5:0] k_rem;
    logic [EXP_W-1:0] expo;
    logic [MANT_W-1:0] mant;
    logic [MANT_W-1:0] imant;
    lvq_point_vec_t points;
    lvq_coef_vec_t recon;
    lvq_band_vec_t bands;
    logic done;
  } lvq_state_t;

  lvq_state_t s;
  lvq_state_t next_s;

  // ----------------------------------------------------------------
  // Candidate search in one coset of the even lattice
  // ----------------------------------------------------------------
  // Works on the scaled sub-band with NORM_FRAC fraction bits
  function automatic lvq_y_t coset_point(input lvq_norm_t x, input logic odd);
    logic signed [63:0] xi;
    logic signed [63:0] t;
    logic signed [63:0] err;
    logic signed [63:0] worst;
    logic signed [63:0] worst_err;
    logic signed [63:0] sum;
    logic signed [63:0] yv [DIM];
    int idx;
    lvq_y_t y;
    worst = '0;
    worst_err = '0;
    sum = '0;
    idx = 0;
    y = '0;
    for (int i = 0; i < DIM; i++) begin
      xi = 64'($signed(x[i])) - (odd ? 64'sd1 <<< NORM_FRAC : 64'sd0);
      t = (xi + (64'sd1 <<< NORM_FRAC)) >>> (NORM_FRAC + 1);
      yv[i] = t <<< 1;
      sum = sum + yv[i];
      err = xi - (yv[i] <<< NORM_FRAC);
      // First component with the largest error wins a tie
      if ((err < 0 ? -err : err) > worst) begin
        worst = err < 0 ? -err : err;
        worst_err = err;
        idx = i;
      end
    end
    if (sum[1:0] != 2'b00) begin
      yv[idx] = (worst_err < 0) ? yv[idx] - 64'sd2 : yv[idx] + 64'sd2;
    end
    for (int i = 0; i < DIM; i++) begin
      y[i] = Y_W'(odd ? yv[i] + 64'sd1 : yv[i]);
    end
    return y;
  endfunction : coset_point

  // Squared distance of a candidate from the scaled sub-band
  function automatic logic signed [63:0] sq_err(input lvq_norm_t x, input lvq_y_t y);
    logic signed [63:0] d;
    logic signed [63:0] acc;
    acc = '0;
    for (int i = 0; i < DIM; i++) begin
      d = 64'($signed(x[i])) - (64'($signed(y[i])) <<< NORM_FRAC);
      acc = acc + d * d;
    end
    return acc;
  endfunction : sq_err

  // Sphere number: squared norm over eight
  function automatic int sphere(input lvq_y_t y);
    int acc;
    acc = 0;
    for (int i = 0; i < DIM; i++) begin
      acc = acc + int'($signed(y[i])) * int'($signed(y[i]));
    end
    return acc / 8;
  endfunction : sphere

  // ----------------------------------------------------------------
  // Codebook number and base / extension split
  // ----------------------------------------------------------------
  // Membership is judged on the sphere alone; leader ranking is done downstream
  function automatic lvq_band_t classify(input lvq_y_t y);
    lvq_band_t b;
    lvq_y_t z;
    int m;
    logic hit;
    b = '0;
    z = '0;
    hit = 1'b0;
    m = sphere(y);
    b.base_point = y;
    if (m == 0) begin
      b.cb_num = 4'h0;
      hit = 1'b1;
    end else if (m <= SPH_Q4) begin
      b.cb_num = (m <= SPH_Q2) ? 4'h2 : (m <= SPH_Q3) ? 4'h3 : 4'h4;
      hit = 1'b1;
    end
    for (int r = 1; r <= MAX_ORDER; r++) begin
      if (!hit) begin
        for (int i = 0; i < DIM; i++) begin
          z[i] = Y_W'($signed(y[i]) >>> r);
        end
        m = sphere(z);
        if (m <= SPH_Q4) begin
          hit = 1'b1;
          b.cb_num = 4'((m <= SPH_Q3 ? 3 : 4) + 2 * r);
          b.ext_order = 2'(r);
          b.base_point = z;
          for (int i = 0; i < DIM; i++) begin
            b.ext_point[i] = Y_W'($signed(y[i]) - ($signed(z[i]) <<< r));
          end
        end
      end
    end
    // Too far out even at the top order: flagged, coded with the largest number
    if (!hit) begin
      b.no_fit = 1'b1;
      b.cb_num = 4'(EXT_THRESH + 2 * MAX_ORDER);
      b.ext_order = 2'(MAX_ORDER);
      b.base_point = z;
    end
    return b;
  endfunction : classify

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [ENER_W-1:0] energy;
  logic [ENER_W-1:0] ener_shift;
  logic [31:0] lsq;
  logic [LOG_FRAC-1:0] nfrac;
  logic signed [R_W-1:0] log_val;
  logic signed [R_W-1:0] trial;
  logic signed [31:0] excess;
  logic signed [31:0] ceiling;
  logic [9:0] quarters;
  lvq_norm_t xn0;
  lvq_norm_t xn;
  lvq_y_t y_even;
  lvq_y_t y_odd;
  lvq_y_t y_pick;
  logic signed [63:0] prod;
  logic signed [31:0] rem;
  int msb;
  int last_nz;
  int cost;

  always_comb begin
    next_s = s;
    energy = '0;
    ener_shift = '0;
    lsq = '0;
    nfrac = '0;
    log_val = '0;
    trial = '0;
    excess = '0;
    ceiling = '0;
    quarters = '0;
    xn0 = '0;
    xn = '0;
    y_even = '0;
    y_odd = '0;
    y_pick = '0;
    prod = '0;
    rem = '0;
    msb = 0;
    last_nz = -1;
    cost = 0;
    case (s.phase)
      LVQ_IDLE, LVQ_DONE: begin
        if (start) begin
          next_s.phase = LVQ_LOG;
          next_s.band = '0;
          next_s.cnt = '0;
          next_s.done = 1'b0;
        end
      end
      LVQ_LOG: begin
        if (s.cnt == 4'h0) begin
          for (int i = 0; i < DIM; i++) begin
            prod = 64'($signed(coef_in[8 * s.band + 3'(i)]));
            energy = energy + ENER_W'(prod * prod);
          end
          if (energy < ENER_W'(ENERGY_FLOOR) << ENER_FRAC) begin
            energy = ENER_W'(ENERGY_FLOOR) << ENER_FRAC;
          end
          for (int i = 0; i < ENER_W; i++) begin
            if (energy[i]) begin
              msb = i;
            end
          end
          ener_shift = energy << (ENER_W - 1 - msb);
          next_s.lmant = ener_shift[ENER_W-1 -: LMANT_W];
          next_s.lint = 8'(msb - ENER_FRAC);
          next_s.lfrac = '0;
          next_s.cnt = 4'h1;
        end else begin
          // Fraction bits by repeated squaring, one bit per cycle
          lsq = 32'(s.lmant) * 32'(s.lmant);
          next_s.lmant = lsq[31] ? lsq[31:16] : lsq[30:15];
          nfrac = {s.lfrac[LOG_FRAC-2:0], lsq[31]};
          next_s.lfrac = nfrac;
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == 4'(LOG_FRAC)) begin
            log_val = (R_W'(s.lint) <<< LOG_FRAC) + R_W'(nfrac);
            next_s.rate[s.band] = R_W'(BITS_PER_LOG * (log_val - (R_W'(1) <<< LOG_FRAC)));
            next_s.cnt = '0;
            next_s.band = s.band + 3'h1;
            if (s.band == 3'(SUBBAND_COUNT - 1)) begin
              next_s.phase = LVQ_SEARCH;
              next_s.fac = R_W'(STEP_INIT) <<< LOG_FRAC;
              next_s.offset = '0;
            end
          end
        end
      end
      LVQ_SEARCH: begin
        // Ceiling in LOG_FRAC units; negative budget simply forces the largest gain
        ceiling = ((32'($signed({1'b0, available_bit_count})) - 32'(SUBBAND_COUNT)) <<< LOG_FRAC)
          * CEIL_NUM / CEIL_DEN;
        trial = s.offset + s.fac;
        for (int j = 0; j < SUBBAND_COUNT; j++) begin
          if ($signed(s.rate[j]) > trial) begin
            excess = excess + 32'($signed(s.rate[j]) - trial);
          end
        end
        next_s.offset = (excess <= ceiling) ? s.offset : trial;
        next_s.fac = s.fac >>> 1;
        next_s.cnt = s.cnt + 4'h1;
        if (s.cnt == 4'(SEARCH_ITERS - 1)) begin
          next_s.phase = LVQ_GAIN;
          next_s.cnt = '0;
        end
      end
      LVQ_GAIN: begin
        if (s.cnt == 4'h0) begin
          // Offset steps are quarters; gain is two to the offset over ten
          quarters = s.offset[LOG_FRAC + 7 -: 10];
          next_s.expo = EXP_W'(quarters / QUARTERS_PER_OCTAVE);
          next_s.k_rem = 6'(quarters % QUARTERS_PER_OCTAVE);
          next_s.mant = MANT_ONE;
          next_s.imant = MANT_ONE;
          next_s.cnt = 4'h1;
        end else if (s.k_rem != '0) begin
          // Stepwise powers keep the table out at the cost of up to 39 cycles
          prod = 64'(s.mant) * 64'(MANT_UP);
          next_s.mant = MANT_W'(prod >>> MANT_FRAC);
          prod = 64'(s.imant) * 64'(MANT_DOWN);
          next_s.imant = MANT_W'(prod >>> MANT_FRAC);
          next_s.k_rem = s.k_rem - 6'h1;
        end else begin
          next_s.phase = LVQ_QUANT;
          next_s.band = '0;
        end
      end
      LVQ_QUANT: begin
        for (int i = 0; i < DIM; i++) begin
          prod = 64'($signed(coef_in[8 * s.band + 3'(i)])) * 64'(s.imant);
          xn[i] = NORM_W'(prod >>> (COEF_FRAC + MANT_FRAC - NORM_FRAC + 32'(s.expo)));
        end
        y_even = coset_point(xn, 1'b0);
        y_odd = coset_point(xn, 1'b1);
        y_pick = (sq_err(xn, y_even) > sq_err(xn, y_odd)) ? y_even : y_odd;
        for (int i = 0; i < DIM; i++) begin
          next_s.points[8 * s.band + 3'(i)] = y_pick[i];
          prod = (64'($signed(y_pick[i])) * 64'(s.mant)) <<< s.expo;
          next_s.recon[8 * s.band + 3'(i)] = COEF_W'(prod >>> (MANT_FRAC - COEF_FRAC));
        end
        next_s.bands[s.band] = classify(y_pick);
        next_s.band = s.band + 3'h1;
        if (s.band == 3'(SUBBAND_COUNT - 1)) begin
          next_s.phase = LVQ_CODE;
        end
      end
      LVQ_CODE: begin
        rem = 32'(available_bit_count);
        for (int j = 0; j < SUBBAND_COUNT; j++) begin
          if (s.bands[j].cb_num != 4'h0) begin
            last_nz = j;
          end
        end
        for (int j = 0; j < SUBBAND_COUNT; j++) begin
          cost = (s.bands[j].cb_num == 4'h0) ? 1 : 5 * int'(s.bands[j].cb_num);
          if (s.bands[j].cb_num == 4'h0) begin
            next_s.bands[j].unary_code = 8'h00;
            next_s.bands[j].unary_len = 4'h1;
          end else if (j == last_nz && rem == 32'(cost - 1)) begin
            next_s.bands[j].unary_code = 8'((9'h001 << (s.bands[j].cb_num - 4'h1)) - 9'h001);
            next_s.bands[j].unary_len = s.bands[j].cb_num - 4'h1;
          end else begin
            next_s.bands[j].unary_code = 8'(((9'h001 << (s.bands[j].cb_num - 4'h1)) - 9'h001) << 1);
            next_s.bands[j].unary_len = s.bands[j].cb_num;
          end
          rem = rem - 32'(cost);
        end
        next_s.phase = LVQ_DONE;
        next_s.done = 1'b1;
      end
      default: begin
        next_s.phase = LVQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{phase: LVQ_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state
  assign busy = (s.phase != LVQ_IDLE) && (s.phase != LVQ_DONE);
  assign done = s.done;
  assign gain = GAIN_W'(s.mant) << s.expo;
  assign quant_point = s.points;
  assign quant_spectrum = s.recon;
  assign band_index = s.bands;

endmodule : lvq_core

// ==== rtl/lvq_pkg.sv ====
// Constants, field widths and carrier types of the lattice vector quantizer.
// Assumes one 200 MHz core clock and a single upstream and downstream party.
// Behaviour
// - A job carries 64 coefficients, handled as eight independent eight-coefficient sub-bands.
// - Sub-band energy is the sum of squares, never below two.
// - Bit estimate per sub-band is five times log2 of half the energy.
// - Search starts with step 128, offset zero, ceiling 0.95 of bits minus sub-bands.
// - Ten iterations: add step, sum positive excess, undo if within ceiling, halve step.
// - Gain is two to the offset over ten; every coefficient is divided by it.
// - Even candidate: halve, round to nearest, double each component.
// - If sum not multiple of four, move worst component by two toward input.
// - Odd candidate: subtract one, same rounding and correction, add one back.
// - Even candidate chosen only if its squared error strictly exceeds the odd one's.
// - Quantized blocks are multiplied by the gain to rebuild the spectrum.
// - Index is codebook number, base vector and, above four, an extension part.
// - Points inside a base codebook carry only the codebook number and base vector.
// - Points outside are split by scale into a base and extension point, number above four.
// - Codebook number n is sent in n bits; zero takes one bit.
// - Unary code is ones ended by a zero; numbers 0 and 2 to 8.
// - Last nonzero sub-band with exactly 5n-1 bits left drops the ending zero.
package lvq_pkg;

  // ----------------------------------------------------------------
  // Sizes and fixed-point formats
  // ----------------------------------------------------------------
  localparam int N_COEF = 64;
  localparam int SUBBAND_COUNT = 8;
  localparam int DIM = 8;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 4;
  localparam int ENER_W = 36;
  localparam int ENER_FRAC = 2 * COEF_FRAC;
  localparam int LOG_FRAC = 8;
  localparam int LMANT_W = 16;
  localparam int R_W = 20;
  localparam int NORM_FRAC = 8;
  localparam int NORM_W = 24;
  localparam int Y_W = 14;
  localparam int MANT_FRAC = 16;
  localparam int MANT_W = 18;
  localparam int EXP_W = 5;
  localparam int GAIN_W = 44;
  localparam int BITS_W = 16;

  // ----------------------------------------------------------------
  // Algorithm constants
  // ----------------------------------------------------------------
  localparam int ENERGY_FLOOR = 2;
  localparam int BITS_PER_LOG = 5;
  localparam int STEP_INIT = 128;
  localparam int CEIL_NUM = 19;
  localparam int CEIL_DEN = 20;
  localparam int SEARCH_ITERS = 10;
  localparam int QUARTERS_PER_OCTAVE = 40;
  localparam logic [MANT_W-1:0] MANT_ONE = 18'h10000;
  localparam logic [MANT_W-1:0] MANT_UP = 18'h1047A;
  localparam logic [MANT_W-1:0] MANT_DOWN = 18'h0FB9A;
  localparam int EXT_THRESH = 4;
  localparam int MAX_ORDER = 2;
  localparam int SPH_Q2 = 2;
  localparam int SPH_Q3 = 4;
  localparam int SPH_Q4 = 8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef logic [N_COEF-1:0][COEF_W-1:0] lvq_coef_vec_t;
  typedef logic [N_COEF-1:0][Y_W-1:0] lvq_point_vec_t;
  typedef logic [DIM-1:0][Y_W-1:0] lvq_y_t;
  typedef logic [DIM-1:0][NORM_W-1:0] lvq_norm_t;

  typedef struct packed {
    logic [3:0] cb_num;
    logic [7:0] unary_code;
    logic [3:0] unary_len;
    logic [1:0] ext_order;
    logic no_fit;
    lvq_y_t base_point;
    lvq_y_t ext_point;
  } lvq_band_t;

  typedef lvq_band_t [SUBBAND_COUNT-1:0] lvq_band_vec_t;

  typedef enum logic [2:0] {
    LVQ_IDLE,
    LVQ_LOG,
    LVQ_SEARCH,
    LVQ_GAIN,
    LVQ_QUANT,
    LVQ_CODE,
    LVQ_DONE
  } lvq_phase_t;

endpackage : lvq_pkg
